//--- rtl/pmcs_pkg.sv
package pmcs_pkg;
  // ==========================================================================
  // Clock-select field codes
  // ==========================================================================
  localparam logic [1:0] CS_PRIMARY = 2'h0;   // Primary clock as configured
  localparam logic [1:0] CS_SECONDARY = 2'h1; // Timer-one oscillator
  localparam int CS_INTERNAL_BIT = 1;         // Bit 1 set selects internal block

  // ==========================================================================
  // Register layout and reset values
  // ==========================================================================
  localparam int IDLE_ENABLE_BIT = 7;                  // Position in control reg
  localparam int FREQ_SEL_LSB = 4;                     // Frequency field low bit
  localparam int CLK_SEL_LSB = 0;                      // Clock-select low bit
  localparam logic [7:0] OSC_CTRL_RESET = 8'h00;       // Reset: Sleep on trigger
  localparam logic [2:0] FREQ_LOW_RC = 3'h0;           // Low-freq RC directly
  localparam logic [2:0] FREQ_8MHZ = 3'h7;             // 8 MHz direct

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int SWITCH_COUNT = 8;                     // New-source cycles counted
  localparam int CLK_PERIOD_NS = 20;                   // 50 MHz system clock
  localparam int WAKE_DELAY_US = 10;                   // CPU hold-off after wake
  localparam int WAKE_DELAY_CYC = (WAKE_DELAY_US * 1000) / CLK_PERIOD_NS;

  // ==========================================================================
  // Modes and states
  // ==========================================================================
  typedef enum logic [2:0] {
    MODE_PRIMARY_RUN_MODE = 3'b000,
    MODE_SECONDARY_RUN_MODE = 3'b001,
    MODE_INT_RUN = 3'b010,
    MODE_SLEEP = 3'b011,
    MODE_PRIMARY_IDLE_MODE = 3'b100,
    MODE_SECONDARY_IDLE_MODE = 3'b101,
    MODE_INT_IDLE = 3'b110
  } pmcs_mode_e;

  typedef enum logic [2:0] {
    ST_RUNNING = 3'b000,
    ST_STOPPED = 3'b001,
    ST_COUNTING = 3'b010,
    ST_MANAGED = 3'b011,
    ST_WAKE_HOLD = 3'b100
  } pmcs_state_e;

  // Wake event bundle from the core side
  typedef struct packed {
    logic irq;
    logic reset_req;
    logic watchdog;
  } pmcs_wake_s;

  // Clock ready indications from the oscillators
  typedef struct packed {
    logic primary_ready;
    logic internal_fast_stable;
    logic timer_one_osc_ready;
  } pmcs_ready_s;

  // Source status bits
  typedef struct packed {
    logic primary_running;
    logic internal_stable;
    logic timer_one_running;
  } pmcs_status_s;
endpackage

//--- rtl/pmcs_edge_counter.sv
`timescale 1ns/10ps
// ============================================================================
// Counts rising edges of a new clock source, sampled on the system clock
// ============================================================================
module pmcs_edge_counter
  import pmcs_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,     // Restart the count
  input wire logic src_clk_in,   // New source, already a sampled level
  output logic done_out          // Eight edges seen
);
  // All state of the counter
  typedef struct packed {
    logic [3:0] cnt;
    logic prev;
    logic done;
  } pmcs_cnt_s;

  pmcs_cnt_s cur_ff;
  pmcs_cnt_s nxt_cur;

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.prev = src_clk_in;
    if (start_in) begin
      // Restart clears both count and done
      nxt_cur.cnt = 4'h0;
      nxt_cur.done = 1'b0;
    end else if (src_clk_in && !cur_ff.prev && !cur_ff.done) begin
      // The first edge after the restart ends a partial period and is counted, so the pause is 7 to 8 periods
      nxt_cur.cnt = cur_ff.cnt + 4'h1;
      if (cur_ff.cnt == 4'(SWITCH_COUNT - 1)) begin
        nxt_cur.done = 1'b1;
      end
    end
  end

  // Register the state
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign done_out = cur_ff.done;
endmodule

//--- rtl/pmcs_clock_switch.sv
`timescale 1ns/10ps
// What this block does
// - Clock-select writes wait for sleep trigger
// - Select primary, secondary or internal block
// - Stop clocks on cycle after sleep
// - Count eight new-source cycles before resuming
// - Three one-hot source status bits
// - No bit set: low RC or unstable
// - Internal primary may show two bits
// - Each sleep uses current mode bits
// - Different selection at sleep switches clock
// - Watchdog wakes when managed, resets when running
// - Idle wake runs idle clock, then primary
// - Mode bits untouched by wake-up
// - All-zero selects Sleep, primary stops
// - Sleep wake unclocked until primary ready, unless two-speed runs internal
// - Idle gates CPU clock only
// - Idle leaves only on wake events
// - Hold CPU about ten microseconds after wake
// - Idle enable sits at bit 7
// - Frequency select halves per step
module pmcs_clock_switch
  import pmcs_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic CTRL_WR_IN,               // Control register write strobe
  input wire logic [7:0] CTRL_WDATA_IN,      // Control register write data
  input wire logic SLEEP_EXEC_IN,            // Sleep instruction executed, pulse
  input wire pmcs_wake_s WAKE_IN,            // Wake events, pulses
  input wire pmcs_ready_s READY_IN,          // Oscillator ready levels
  input wire logic PRIMARY_IS_INTERNAL_IN,   // Primary configured as internal
  input wire logic TWO_SPEED_EN_IN,          // Two-speed or fail-safe enabled
  input wire logic NEW_SRC_CLK_IN,           // Sampled level of the target source
  output logic [7:0] CTRL_RDATA_OUT,         // Control register read value
  output pmcs_status_s STATUS_OUT,           // Source status bits
  output pmcs_mode_e MODE_OUT,               // Current power-managed mode
  output logic [1:0] ACTIVE_SRC_OUT,         // Source clocking the system
  output logic [2:0] FREQ_SEL_OUT,           // Internal frequency select
  output logic LOW_RC_DIRECT_OUT,            // Low RC drives the internal mux
  output logic CPU_CLK_EN_OUT,               // CPU clock gate enable
  output logic PERIPH_CLK_EN_OUT,            // Peripheral clock gate enable
  output logic PRIMARY_OSC_EN_OUT,           // Primary oscillator enable
  output logic CPU_HOLD_OUT,                 // CPU may not execute
  output logic WATCHDOG_RESET_OUT            // Watchdog reset pulse
);
  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    pmcs_state_e st;
    logic [7:0] ctrl;          // Control register image
    pmcs_mode_e mode;          // Mode latched at sleep, updated on wake
    logic [1:0] active_src;    // Source now clocking the system
    logic [1:0] target_src;    // Source being switched to
    logic waking;              // Switching back after a wake
    logic [8:0] hold_cnt;      // Wake hold-off counter
    logic cpu_hold;
    logic wdt_reset;
    logic prim_osc_en;
  } pmcs_top_s;

  pmcs_top_s cur_ff;
  pmcs_top_s nxt_cur;
  logic cnt_start;             // Restart the edge counter
  logic cnt_done;              // Eight new-source edges seen
  logic wake_any;              // Any wake event
  logic [1:0] sel_src;         // Decoded selection at the trigger
  logic idle_bit;              // Idle enable at the trigger
  logic sleep_sel;             // Trigger selects full Sleep

  // ==========================================================================
  // Source decode
  // ==========================================================================
  // Bit 1 alone picks the internal block; the low bit is a don't-care then
  function automatic logic [1:0] decode_src(input logic [1:0] cs);
    logic [1:0] r;
    r = CS_PRIMARY;
    if (cs[CS_INTERNAL_BIT]) begin
      r = 2'h2;
    end else if (cs == CS_SECONDARY) begin
      r = CS_SECONDARY;
    end
    return r;
  endfunction

  // Mode from the idle bit and decoded source
  function automatic pmcs_mode_e mode_of(input logic idle, input logic [1:0] src);
    pmcs_mode_e m;
    m = MODE_PRIMARY_RUN_MODE;
    case (src)
      2'h1: begin
        m = idle ? MODE_SECONDARY_IDLE_MODE : MODE_SECONDARY_RUN_MODE;
      end
      2'h2: begin
        m = idle ? MODE_INT_IDLE : MODE_INT_RUN;
      end
      default: begin
        m = idle ? MODE_PRIMARY_IDLE_MODE : MODE_SLEEP;
      end
    endcase
    return m;
  endfunction

  // Values taken at the moment of the trigger
  always_comb begin
    idle_bit = cur_ff.ctrl[IDLE_ENABLE_BIT];
    sel_src = decode_src(cur_ff.ctrl[CLK_SEL_LSB +: 2]);
    sleep_sel = !idle_bit && (sel_src == CS_PRIMARY);
    wake_any = WAKE_IN.irq || WAKE_IN.reset_req || WAKE_IN.watchdog;
  end

  // ==========================================================================
  // Eight-edge counter for glitch-free switching
  // ==========================================================================
  pmcs_edge_counter u_edge_counter (
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .start_in(cnt_start),
    .src_clk_in(NEW_SRC_CLK_IN),
    .done_out(cnt_done)
  );

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.wdt_reset = 1'b0;
    cnt_start = 1'b0;
    // Software writes only land in the image; the source stays put
    if (CTRL_WR_IN) begin
      nxt_cur.ctrl = CTRL_WDATA_IN;
    end
    case (cur_ff.st)
      ST_RUNNING: begin
        if (SLEEP_EXEC_IN) begin
          // Latch mode now; a later write cannot alter this entry
          nxt_cur.mode = mode_of(idle_bit, sel_src);
          nxt_cur.target_src = sel_src;
          nxt_cur.waking = 1'b0;
          nxt_cur.cpu_hold = 1'b1;
          if (sleep_sel) begin
            nxt_cur.prim_osc_en = 1'b0;
            nxt_cur.st = ST_MANAGED;
          end else begin
            // Clocks stop on the next cycle, switch or not
            nxt_cur.st = ST_STOPPED;
          end
          cnt_start = 1'b1;
        end else if (WAKE_IN.watchdog) begin
          nxt_cur.wdt_reset = 1'b1;
        end else if (cur_ff.active_src != CS_PRIMARY && READY_IN.primary_ready
                     && cur_ff.waking) begin
          // Primary became ready after a wake: move back to it
          nxt_cur.target_src = CS_PRIMARY;
          nxt_cur.st = ST_STOPPED;
          cnt_start = 1'b1;
        end
      end
      ST_STOPPED: begin
        // Same source needs no pause
        if (cur_ff.target_src == cur_ff.active_src) begin
          nxt_cur.st = ST_COUNTING;
        end else if (cnt_done) begin
          nxt_cur.st = ST_COUNTING;
        end
      end
      ST_COUNTING: begin
        nxt_cur.active_src = cur_ff.target_src;
        if (cur_ff.waking || cur_ff.mode inside {MODE_PRIMARY_RUN_MODE, MODE_SECONDARY_RUN_MODE,
                                                 MODE_INT_RUN}) begin
          nxt_cur.cpu_hold = 1'b0;
          nxt_cur.waking = 1'b0;
          nxt_cur.st = ST_RUNNING;
        end else begin
          nxt_cur.st = ST_MANAGED;
        end
        if (cur_ff.waking) begin
          nxt_cur.mode = MODE_PRIMARY_RUN_MODE;
        end
      end
      ST_MANAGED: begin
        // Only interrupt, watchdog or reset leave a managed idle
        if (wake_any) begin
          nxt_cur.hold_cnt = 9'(WAKE_DELAY_CYC);
          nxt_cur.prim_osc_en = 1'b1;
          nxt_cur.st = ST_WAKE_HOLD;
        end
      end
      default: begin
        // Wake hold-off; the control image is left alone
        if (cur_ff.hold_cnt != 9'h000) begin
          nxt_cur.hold_cnt = cur_ff.hold_cnt - 9'h001;
        end else if (cur_ff.mode == MODE_SLEEP) begin
          // Sleep waits for primary unless two-speed runs internal
          if (READY_IN.primary_ready) begin
            nxt_cur.active_src = CS_PRIMARY;
            nxt_cur.mode = MODE_PRIMARY_RUN_MODE;
            nxt_cur.cpu_hold = 1'b0;
            nxt_cur.st = ST_RUNNING;
          end else if (TWO_SPEED_EN_IN) begin
            nxt_cur.active_src = 2'h2;
            nxt_cur.mode = MODE_INT_RUN;
            nxt_cur.waking = 1'b1;
            nxt_cur.cpu_hold = 1'b0;
            nxt_cur.st = ST_RUNNING;
          end
        end else begin
          // Idle wake: same source in the matching run mode
          case (cur_ff.mode)
            MODE_SECONDARY_IDLE_MODE: nxt_cur.mode = MODE_SECONDARY_RUN_MODE;
            MODE_INT_IDLE: nxt_cur.mode = MODE_INT_RUN;
            default: nxt_cur.mode = MODE_PRIMARY_RUN_MODE;
          endcase
          nxt_cur.waking = (cur_ff.active_src != CS_PRIMARY);
          nxt_cur.cpu_hold = 1'b0;
          nxt_cur.st = ST_RUNNING;
        end
      end
    endcase
  end

  // Register the state
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cur_ff.st <= ST_RUNNING;
      cur_ff.ctrl <= OSC_CTRL_RESET;
      cur_ff.mode <= MODE_PRIMARY_RUN_MODE;
      cur_ff.active_src <= CS_PRIMARY;
      cur_ff.target_src <= CS_PRIMARY;
      cur_ff.waking <= 1'b0;
      cur_ff.hold_cnt <= 9'h000;
      cur_ff.cpu_hold <= 1'b0;
      cur_ff.wdt_reset <= 1'b0;
      cur_ff.prim_osc_en <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  always_comb begin
    logic clocked;
    logic is_idle;
    clocked = (cur_ff.st != ST_STOPPED) && (cur_ff.st != ST_COUNTING);
    is_idle = cur_ff.mode inside {MODE_PRIMARY_IDLE_MODE, MODE_SECONDARY_IDLE_MODE, MODE_INT_IDLE};
    // Idle gates only the CPU; Sleep gates everything
    PERIPH_CLK_EN_OUT = clocked && !(cur_ff.st == ST_MANAGED && cur_ff.mode == MODE_SLEEP)
                        && !(cur_ff.st == ST_WAKE_HOLD && cur_ff.mode == MODE_SLEEP);
    CPU_CLK_EN_OUT = clocked && (cur_ff.st == ST_RUNNING);
    if (cur_ff.st == ST_MANAGED && is_idle) begin
      CPU_CLK_EN_OUT = 1'b0;
    end
    // Status: one bit per source; internal primary may show two
    STATUS_OUT.primary_running = clocked && cur_ff.prim_osc_en
                                 && cur_ff.active_src == CS_PRIMARY
                                 && cur_ff.mode != MODE_SLEEP
                                 && READY_IN.primary_ready;
    STATUS_OUT.internal_stable = clocked && READY_IN.internal_fast_stable
      && cur_ff.ctrl[FREQ_SEL_LSB +: 3] != FREQ_LOW_RC
      && (cur_ff.active_src == 2'h2
          || (PRIMARY_IS_INTERNAL_IN && STATUS_OUT.primary_running));
    STATUS_OUT.timer_one_running = clocked && cur_ff.active_src == CS_SECONDARY
                                   && READY_IN.timer_one_osc_ready;
    // Neither bit set means low RC or unsettled fast oscillator
    FREQ_SEL_OUT = cur_ff.ctrl[FREQ_SEL_LSB +: 3];
    LOW_RC_DIRECT_OUT = (FREQ_SEL_OUT == FREQ_LOW_RC);
  end

  assign CTRL_RDATA_OUT = {cur_ff.ctrl[7:4], STATUS_OUT.primary_running,
                           STATUS_OUT.internal_stable, cur_ff.ctrl[1:0]};
  assign MODE_OUT = cur_ff.mode;
  assign ACTIVE_SRC_OUT = cur_ff.active_src;
  assign PRIMARY_OSC_EN_OUT = cur_ff.prim_osc_en;
  assign CPU_HOLD_OUT = cur_ff.cpu_hold;
  assign WATCHDOG_RESET_OUT = cur_ff.wdt_reset;
endmodule

//--- verification/pmcs_clock_switch_props.sv
`timescale 1ns/10ps
// ========================================
// Port checker for the clock switch
module pmcs_clock_switch_props
  import pmcs_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic CTRL_WR_IN,
  input wire logic [7:0] CTRL_WDATA_IN,
  input wire logic SLEEP_EXEC_IN,
  input wire pmcs_wake_s WAKE_IN,
  input wire pmcs_ready_s READY_IN,
  input wire logic [7:0] CTRL_RDATA_OUT,
  input wire pmcs_status_s STATUS_OUT,
  input wire pmcs_mode_e MODE_OUT,
  input wire logic [1:0] ACTIVE_SRC_OUT,
  input wire logic CPU_CLK_EN_OUT,
  input wire logic PERIPH_CLK_EN_OUT,
  input wire logic CPU_HOLD_OUT,
  input wire logic WATCHDOG_RESET_OUT
);
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);
  logic [9:0] hold_len_ff; // Cycles the CPU hold has stood so far
  logic [9:0] nxt_hold_len;
  logic idle_wake_ff; // Last wake came from an idle mode, so no wait for primary
  logic managed; // Idle or sleep: watchdog must wake, not reset
  assign managed = MODE_OUT[2] || (MODE_OUT == MODE_SLEEP);
  // Hold length counted from the wake event, not from sleep entry, which also holds
  always_comb begin
    nxt_hold_len = 10'h000;
    if ((|WAKE_IN) && managed) begin
      nxt_hold_len = 10'h001;
    end else if (CPU_HOLD_OUT && hold_len_ff != 10'h000 && hold_len_ff != 10'h3ff) begin
      nxt_hold_len = hold_len_ff + 10'h001;
    end else if (CPU_HOLD_OUT) begin
      nxt_hold_len = hold_len_ff;
    end
  end
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      hold_len_ff <= 10'h000;
      idle_wake_ff <= 1'b0;
    end else begin
      hold_len_ff <= nxt_hold_len;
      if ((|WAKE_IN) && managed) begin
        idle_wake_ff <= MODE_OUT[2];
      end
    end
  end
  a_sleep_stops_cpu: assert property (SLEEP_EXEC_IN && CPU_CLK_EN_OUT && !CPU_HOLD_OUT
    |=> !CPU_CLK_EN_OUT) else $error("CPU clock not stopped after sleep");
  a_wdt_run_reset: assert property (WAKE_IN.watchdog && CPU_CLK_EN_OUT && !CPU_HOLD_OUT
    && !managed |=> WATCHDOG_RESET_OUT) else $error("watchdog in run gave no reset");
  a_wdt_managed_wake: assert property (WAKE_IN.watchdog && managed
    |=> !WATCHDOG_RESET_OUT) else $error("watchdog reset while managed");
  a_idle_cpu_gated: assert property (MODE_OUT[2] |-> !CPU_CLK_EN_OUT)
    else $error("CPU clocked in idle");
  a_sleep_unclocked: assert property (MODE_OUT == MODE_SLEEP && !READY_IN.primary_ready
    |-> !CPU_CLK_EN_OUT && !PERIPH_CLK_EN_OUT) else $error("clocked in sleep");
  a_status_one_hot: assert property (managed && MODE_OUT != MODE_PRIMARY_IDLE_MODE
    |-> $onehot0(STATUS_OUT)) else $error("more than one source bit");
  a_write_visible: assert property (CTRL_WR_IN |=> {CTRL_RDATA_OUT[7:4],
    CTRL_RDATA_OUT[1:0]} == {$past(CTRL_WDATA_IN[7:4]), $past(CTRL_WDATA_IN[1:0])})
    else $error("control write not stored");
  a_bits_kept: assert property (!CTRL_WR_IN |=> $stable({CTRL_RDATA_OUT[7:4],
    CTRL_RDATA_OUT[1:0]})) else $error("mode bits changed without write");
  a_src_after_stop: assert property ($changed(ACTIVE_SRC_OUT)
    |-> !$past(PERIPH_CLK_EN_OUT)) else $error("source changed while clocked");
  a_wake_hold_len: assert property ($fell(CPU_HOLD_OUT) && hold_len_ff != 10'h000
    |-> hold_len_ff >= WAKE_DELAY_CYC
        && (!idle_wake_ff || hold_len_ff <= (WAKE_DELAY_CYC + 2)))
    else $error("wake hold length wrong");
endmodule
bind pmcs_clock_switch pmcs_clock_switch_props u_props (
  .CLK_SYS_IN, .RST_IN, .CTRL_WR_IN, .CTRL_WDATA_IN, .SLEEP_EXEC_IN, .WAKE_IN, .READY_IN,
  .CTRL_RDATA_OUT, .STATUS_OUT, .MODE_OUT, .ACTIVE_SRC_OUT, .CPU_CLK_EN_OUT,
  .PERIPH_CLK_EN_OUT, .CPU_HOLD_OUT, .WATCHDOG_RESET_OUT
);

//--- verification/pmcs_core_model.sv
`timescale 1ns/10ps
// ========================================
// Core model: sleep trigger, wake events, target source clock
module pmcs_core_model
  import pmcs_pkg::*;
(
  input wire logic clk_in,
  input wire logic src_run_in, // Target source runs only when asked
  output logic sleep_exec_out,
  output pmcs_wake_s wake_out,
  output logic src_clk_out
);
  logic [1:0] div_ff; // Quarter-rate divider for the target source
  initial begin
    sleep_exec_out = 1'h0;
    wake_out = 3'h0;
    div_ff = 2'h0;
  end
  // Source stands still low when not running, so no stale edge is seen
  always @(negedge clk_in) begin
    div_ff <= src_run_in ? div_ff + 2'h1 : 2'h0;
  end
  assign src_clk_out = div_ff[1];
  // One-cycle trigger; caller enters at a falling edge
  task automatic do_sleep();
    sleep_exec_out = 1'h1;
    @(negedge clk_in);
    sleep_exec_out = 1'h0;
  endtask
  // Only interrupt, reset request or watchdog ever wake the block
  task automatic do_wake(input pmcs_wake_s ev);
    wake_out = ev;
    @(negedge clk_in);
    wake_out = 3'h0;
  endtask
endmodule

//--- verification/pmcs_clock_switch_tb.sv
`timescale 1ns/10ps
module pmcs_clock_switch_tb;
  import pmcs_pkg::*;
  logic clk, rst, wr, src_run, sleep_exec, src_clk, cpu_en, per_en, osc_en, hold, wdt_rst;
  logic two_spd, low_rc;
  logic [2:0] freq;
  logic [7:0] wdata, rdata;
  logic [1:0] active;
  pmcs_ready_s ready;
  pmcs_wake_s wake;
  pmcs_status_s status;
  pmcs_mode_e mode;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int edges = 0;
  int i;
  int k;
  // ========================================
  // Design, core model, clock
  pmcs_clock_switch u_dut (.CLK_SYS_IN(clk), .RST_IN(rst), .CTRL_WR_IN(wr),
    .CTRL_WDATA_IN(wdata), .SLEEP_EXEC_IN(sleep_exec), .WAKE_IN(wake), .READY_IN(ready),
    .PRIMARY_IS_INTERNAL_IN(1'h0), .TWO_SPEED_EN_IN(two_spd), .NEW_SRC_CLK_IN(src_clk),
    .CTRL_RDATA_OUT(rdata), .STATUS_OUT(status), .MODE_OUT(mode), .ACTIVE_SRC_OUT(active),
    .FREQ_SEL_OUT(freq), .LOW_RC_DIRECT_OUT(low_rc), .CPU_CLK_EN_OUT(cpu_en),
    .PERIPH_CLK_EN_OUT(per_en),
    .PRIMARY_OSC_EN_OUT(osc_en), .CPU_HOLD_OUT(hold), .WATCHDOG_RESET_OUT(wdt_rst));
  pmcs_core_model u_core (.clk_in(clk), .src_run_in(src_run), .sleep_exec_out(sleep_exec),
    .wake_out(wake), .src_clk_out(src_clk));
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  always @(posedge src_clk) edges++;
  // Cut a hang short; the whole run needs about 2000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      num_errors++;
      give_verdict();
    end
  end
  // ========================================
  // Shared tasks
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'h1) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic do_reset(input int n);
    rst = 1'h1;
    ready = 3'h7;
    src_run = 1'h0;
    repeat (n) @(negedge clk);
    rst = 1'h0;
    @(negedge clk);
  endtask
  task automatic wr_ctrl(input logic [7:0] v);
    wdata = v;
    wr = 1'h1;
    @(negedge clk);
    wr = 1'h0;
  endtask
  // Bounded wait for the peripheral clock to come back after a switch
  task automatic wait_per();
    for (i = 0; i < 100 && per_en !== 1'h1; i++) @(negedge clk);
  endtask
  // ========================================
  // Scenarios
  task automatic t_run_watchdog();
    chk({rdata[7:4], rdata[1:0]} === 6'h00 && mode === MODE_PRIMARY_RUN_MODE, "reset state");
    u_core.do_wake(3'h1);
    chk(wdt_rst === 1'h1, "no watchdog reset in run");
    @(negedge clk);
    chk(wdt_rst === 1'h0 && mode === MODE_PRIMARY_RUN_MODE, "reset pulse too long");
    $display("test run_watchdog done");
  endtask
  task automatic t_sleep();
    do_reset(2);
    src_run = 1'h1;
    u_core.do_sleep();
    chk(cpu_en === 1'h0 && per_en === 1'h0, "clocks run after sleep");
    chk(mode === MODE_SLEEP && osc_en === 1'h0 && status.primary_running === 1'h0, "no sleep");
    ready.primary_ready = 1'h0;
    repeat (20) @(negedge clk);
    chk(mode === MODE_SLEEP, "left sleep unprompted");
    u_core.do_wake(3'h4);
    repeat (20) @(negedge clk);
    chk(cpu_en === 1'h0 && per_en === 1'h0, "clocked before primary ready");
    ready.primary_ready = 1'h1;
    for (i = 0; i < 700 && (cpu_en !== 1'h1 || hold !== 1'h0); i++) @(negedge clk);
    chk(mode === MODE_PRIMARY_RUN_MODE && status.primary_running === 1'h1, "no primary after wake");
    chk({rdata[7:4], rdata[1:0]} === 6'h00, "mode bits changed by wake");
    // Second sleep with two-speed on: internal block runs until primary is ready
    u_core.do_sleep();
    ready.primary_ready = 1'h0;
    two_spd = 1'h1;
    u_core.do_wake(3'h4);
    for (i = 0; i < 600 && hold !== 1'h0; i++) @(negedge clk);
    chk(mode === MODE_INT_RUN && active === 2'h2 && cpu_en === 1'h1, "no two-speed run");
    ready.primary_ready = 1'h1;
    for (i = 0; i < 100 && mode !== MODE_PRIMARY_RUN_MODE; i++) @(negedge clk);
    chk(active === 2'h0 && status.primary_running === 1'h1, "no return to primary");
    two_spd = 1'h0;
    $display("test sleep done");
  endtask
  task automatic t_idle_sec();
    do_reset(2);
    wr_ctrl(8'h81);
    chk(active === 2'h0 && mode === MODE_PRIMARY_RUN_MODE, "switched without sleep");
    src_run = 1'h1;
    edges = 0;
    u_core.do_sleep();
    chk(cpu_en === 1'h0 && per_en === 1'h0, "no stop before switch");
    wait_per();
    chk(edges >= 8 && edges <= 9, "pause not eight source periods");
    chk(mode === MODE_SECONDARY_IDLE_MODE && active === 2'h1 && cpu_en === 1'h0, "secondary idle");
    chk(status === 3'h1, "timer-one status");
    ready.primary_ready = 1'h0;
    u_core.do_wake(3'h1);
    chk(wdt_rst === 1'h0 && hold === 1'h1, "watchdog did not wake");
    for (i = 0; i < 600 && hold !== 1'h0; i++) @(negedge clk);
    chk(i >= 495 && i <= 501, "wake hold length");
    chk(mode === MODE_SECONDARY_RUN_MODE && cpu_en === 1'h1 && active === 2'h1, "not on idle clock");
    ready.primary_ready = 1'h1;
    for (i = 0; i < 100 && mode !== MODE_PRIMARY_RUN_MODE; i++) @(negedge clk);
    chk(active === 2'h0 && status.primary_running === 1'h1, "no automatic return");
    chk(rdata[7] === 1'h1 && rdata[1:0] === 2'h1, "mode bits changed by wake");
    $display("test idle_sec done");
  endtask
  task automatic t_internal();
    for (k = 2; k < 4; k++) begin
      do_reset(2);
      wr_ctrl({4'h7, 2'h0, k[1:0]});
      src_run = 1'h1;
      u_core.do_sleep();
      wait_per();
      chk(mode === MODE_INT_RUN && active === 2'h2 && cpu_en === 1'h1, "internal run");
      chk(status === 3'h2, "internal status");
      chk(freq === FREQ_8MHZ && low_rc === 1'h0, "frequency select");
    end
    wr_ctrl(8'h41);
    u_core.do_sleep();
    wait_per();
    chk(mode === MODE_SECONDARY_RUN_MODE && active === 2'h1, "second sleep kept old bits");
    $display("test internal done");
  endtask
  initial begin
    rst = 1'h1;
    wr = 1'h0;
    wdata = 8'h00;
    src_run = 1'h0;
    two_spd = 1'h0;
    ready = 3'h7;
    repeat (20) @(negedge clk);
    rst = 1'h0;
    @(negedge clk);
    t_run_watchdog();
    t_sleep();
    t_idle_sec();
    t_internal();
    give_verdict();
  end
endmodule
